// >>> hdl/sram_host_pkg.sv
// shared constants and carrier types for the static ram host controller
package sram_host_pkg;
   localparam int ADDR_W = 14;
   localparam int DATA_W = 4;
   // timing figures in ns, slowest grade, and derived cycle counts at 25 MHz
   localparam int CLK_PERIOD_NS = 40;
   localparam int ACCESS_NS = 70;
   localparam int WRITE_PULSE_NS = 50;
   localparam int WRITE_TO_OUTPUT_OFF_DELAY_NS = 25;
   localparam int ACCESS_CYC =
      (ACCESS_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int PULSE_CYC =
      (WRITE_PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int OFF_CYC =
      (WRITE_TO_OUTPUT_OFF_DELAY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   // stages between the data pins and the sequencer
   localparam int SYNC_CYC = 2;
   localparam int CNT_W = 4;
   localparam logic [ADDR_W-1:0] ADDR_RST = 14'h0000;
   localparam logic [DATA_W-1:0] DATA_RST = 4'h0;

   typedef struct packed {
      logic write;
      logic [ADDR_W-1:0] word_address;
      logic [DATA_W-1:0] wdata;
   } request_t;

   typedef struct packed {
      logic chip_sel_n;
      logic out_en_n;
      logic write_en_n;
      logic [ADDR_W-1:0] word_address;
   } pins_t;
endpackage

// >>> hdl/sram_host.sv
// host controller driving a 16k x 4 asynchronous static ram
// Notes on behaviour
// - read: write enable high, select and output low
// - host drives data only after turn-off delay
// - host may hold output enable high
// - write data set-up/hold to write rising
// - select-ended write references select rising
// - address changes only while write high
`timescale 1ns/10ps
module sram_host (
   input wire logic clk_i,
   input wire logic rstn_i,
   input wire logic req_valid_i,
   input wire sram_host_pkg::request_t req_i,
   output logic req_ready_o,
   output logic rdata_valid_o,
   output logic [sram_host_pkg::DATA_W-1:0] rdata_o,
   output sram_host_pkg::pins_t pins_o,
   input wire logic [sram_host_pkg::DATA_W-1:0] dq_i,
   output logic [sram_host_pkg::DATA_W-1:0] dq_o,
   output logic dq_oe_n_o
);
   typedef enum logic [2:0] {
      IDLE, RD_WAIT, WR_SETUP, WR_PULSE, WR_END
   } state_t;

   // ==========================================================
   // counter helpers
   function automatic logic [sram_host_pkg::CNT_W-1:0] cyc(input int n);
      cyc = sram_host_pkg::CNT_W'(n);
   endfunction

   // a count of one or less means the wait ends this cycle
   function automatic logic count_done(
      input logic [sram_host_pkg::CNT_W-1:0] c
   );
      count_done = (c <= cyc(1));
   endfunction

   function automatic logic [sram_host_pkg::CNT_W-1:0] count_down(
      input logic [sram_host_pkg::CNT_W-1:0] c
   );
      count_down = c - cyc(1);
   endfunction

   // ==========================================================
   // pin input synchroniser
   // the ram answers on its own time, so its data pins are treated
   // as asynchronous; only the second stage feeds the sequencer
   logic [sram_host_pkg::DATA_W-1:0] dq_meta_q, dq_meta_d;
   logic [sram_host_pkg::DATA_W-1:0] dq_sync_q, dq_sync_d;

   always_comb begin
      dq_meta_d = dq_i;
      dq_sync_d = dq_meta_q;
   end

   always_ff @(posedge clk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         dq_meta_q <= sram_host_pkg::DATA_RST;
         dq_sync_q <= sram_host_pkg::DATA_RST;
      end else begin
         dq_meta_q <= dq_meta_d;
         dq_sync_q <= dq_sync_d;
      end
   end

   // ==========================================================
   // sequencer
   state_t state_q, state_d;
   // four bits cover the longest wait, access plus synchroniser
   logic [sram_host_pkg::CNT_W-1:0] cnt_q, cnt_d;
   sram_host_pkg::pins_t pins_q, pins_d;
   logic [sram_host_pkg::DATA_W-1:0] dq_q, dq_d;
   logic oe_n_q, oe_n_d;
   // ready stays low for the first cycle after reset
   logic ready_q, ready_d;
   logic rvalid_q, rvalid_d;
   logic [sram_host_pkg::DATA_W-1:0] rdata_q, rdata_d;

   // ==========================================================
   // sequencer next state
   always_comb begin
      state_d = state_q;
      cnt_d = cnt_q;
      pins_d = pins_q;
      dq_d = dq_q;
      oe_n_d = oe_n_q;
      ready_d = ready_q;
      // read valid is a one-cycle pulse
      rvalid_d = 1'b0;
      rdata_d = rdata_q;
      case (state_q)
         IDLE: begin
            // deselect between transfers; nothing is driven
            pins_d.chip_sel_n = 1'b1;
            pins_d.out_en_n = 1'b1;
            // the address only moves while write enable is high
            pins_d.write_en_n = 1'b1;
            oe_n_d = 1'b1;
            ready_d = 1'b1;
            if (req_valid_i && ready_q) begin
               ready_d = 1'b0;
               pins_d.word_address = req_i.word_address;
               dq_d = req_i.wdata;
               if (req_i.write) begin
                  // select first, output enable held high for the
                  // whole write so the ram never fights our data
                  pins_d.chip_sel_n = 1'b0;
                  state_d = WR_SETUP;
                  cnt_d = cyc(sram_host_pkg::OFF_CYC);
               end else begin
                  pins_d.chip_sel_n = 1'b0;
                  pins_d.out_en_n = 1'b0;
                  // access time plus the two synchroniser stages
                  cnt_d = cyc(sram_host_pkg::ACCESS_CYC +
                              sram_host_pkg::SYNC_CYC);
                  state_d = RD_WAIT;
               end
            end
         end

         RD_WAIT: begin
            if (!count_done(cnt_q)) begin
               cnt_d = count_down(cnt_q);
            end else begin
               rdata_d = dq_sync_q;
               rvalid_d = 1'b1;
               pins_d.chip_sel_n = 1'b1;
               pins_d.out_en_n = 1'b1;
               state_d = IDLE;
            end
         end

         WR_SETUP: begin
            // the turn-off delay passes from select before we drive;
            // output enable stays high, so the ram is quiet by then
            if (!count_done(cnt_q)) begin
               cnt_d = count_down(cnt_q);
            end else begin
               // address stable before write falls, write falls last
               pins_d.write_en_n = 1'b0;
               oe_n_d = 1'b0;
               cnt_d = cyc(sram_host_pkg::PULSE_CYC);
               state_d = WR_PULSE;
            end
         end

         WR_PULSE: begin
            // write enable stays low for the whole pulse count
            if (!count_done(cnt_q)) begin
               cnt_d = count_down(cnt_q);
            end else begin
               // write rising ends the cycle; data still held
               pins_d.write_en_n = 1'b1;
               state_d = WR_END;
            end
         end

         WR_END: begin
            // data held one cycle past the write rising edge; select
            // rises with the release, so its hold is met as well
            oe_n_d = 1'b1;
            pins_d.chip_sel_n = 1'b1;
            state_d = IDLE;
         end

         default: begin
            state_d = IDLE;
         end
      endcase
   end

   // ==========================================================
   // sequencer registers
   // the reset state deselects the ram and releases the bus
   always_ff @(posedge clk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         state_q <= IDLE;
         cnt_q <= '0;
         pins_q <= '{chip_sel_n: 1'b1,
                     out_en_n: 1'b1,
                     write_en_n: 1'b1,
                     word_address: sram_host_pkg::ADDR_RST};
         dq_q <= sram_host_pkg::DATA_RST;
         oe_n_q <= 1'b1;
         ready_q <= 1'b0;
         rvalid_q <= 1'b0;
         rdata_q <= sram_host_pkg::DATA_RST;
      end else begin
         state_q <= state_d;
         cnt_q <= cnt_d;
         pins_q <= pins_d;
         dq_q <= dq_d;
         oe_n_q <= oe_n_d;
         ready_q <= ready_d;
         rvalid_q <= rvalid_d;
         rdata_q <= rdata_d;
      end
   end

   // ==========================================================
   // outputs
   // every output is a register; nothing combinational reaches a pin
   assign pins_o = pins_q;
   assign dq_o = dq_q;
   assign dq_oe_n_o = oe_n_q;
   assign req_ready_o = ready_q;
   assign rdata_valid_o = rvalid_q;
   assign rdata_o = rdata_q;
endmodule // sram_host

// >>> verification/sram_model.sv
// behavioural model of the 16k x 4 static ram
`timescale 1ns/10ps
module sram_model (
   input wire sram_host_pkg::pins_t pins_i,
   input wire logic [3:0] dq_i,
   output logic [3:0] q_o,
   output logic oe_o
);
   logic [3:0] mem [0:16383];
   wire rd = !pins_i.chip_sel_n & pins_i.write_en_n & !pins_i.out_en_n;
   wire wr = !pins_i.chip_sel_n & !pins_i.write_en_n;
   assign oe_o = rd;
   initial q_o = 4'h5;
   // junk until the access time runs out, so a hasty sample is caught
   always @(pins_i.word_address or rd) begin
      q_o = ~mem[pins_i.word_address];
      q_o <= #(sram_host_pkg::ACCESS_NS) mem[pins_i.word_address];
   end
   always @(negedge wr) mem[pins_i.word_address] = dq_i;
endmodule // sram_model

// >>> verification/sram_host_checker.sv
// assertions on the host pins
`timescale 1ns/10ps
module sram_host_checker (
   input wire logic clk_i,
   input wire logic rstn_i,
   input wire sram_host_pkg::pins_t pins_o,
   input wire logic [3:0] dq_o,
   input wire logic dq_oe_n_o
);
   default clocking @(posedge clk_i); endclocking
   default disable iff (!rstn_i);
   sequence w_low2;
      !pins_o.write_en_n [*2];
   endsequence
   chk_read_enables: assert property (
      !pins_o.out_en_n |-> pins_o.write_en_n && !pins_o.chip_sel_n)
      else $error("bad read enables");
   chk_no_contend: assert property (
      !dq_oe_n_o |-> pins_o.out_en_n) else $error("bus contention");
   chk_out_high: assert property (
      !pins_o.write_en_n |-> pins_o.out_en_n && !dq_oe_n_o)
      else $error("output enable low in write");
   chk_write_pulse: assert property (
      $fell(pins_o.write_en_n) |-> w_low2 ##1 pins_o.write_en_n)
      else $error("write pulse length");
   chk_data_hold: assert property (
      $rose(pins_o.write_en_n) |-> !dq_oe_n_o && $stable(dq_o))
      else $error("write data not held");
   chk_select_end: assert property (
      $rose(pins_o.chip_sel_n) |-> pins_o.write_en_n)
      else $error("select rose in write");
   chk_addr_steady: assert property (
      !$stable(pins_o.word_address) |->
      pins_o.write_en_n && $past(pins_o.write_en_n))
      else $error("address moved in write");
endmodule // sram_host_checker
bind sram_host sram_host_checker sram_host_checker_i (.clk_i(clk_i),
   .rstn_i(rstn_i), .pins_o(pins_o), .dq_o(dq_o), .dq_oe_n_o(dq_oe_n_o));

// >>> verification/test_sram_host.sv
// self-checking bench for the static ram host
`timescale 1ns/10ps
`define CHK(n, e, a) begin checks_done++; if ((a) !== (e)) begin \
   failures++; $display("mismatch %s exp %h got %h", n, e, a); end end
module test_sram_host;
   logic clk_i = 0, rstn_i = 0, req_valid_i = 0, rv, oe, dq_oe_n;
   logic oe_v;
   localparam int READ_WAIT =
      sram_host_pkg::ACCESS_CYC + sram_host_pkg::SYNC_CYC;
   sram_host_pkg::request_t req_i = '0;
   sram_host_pkg::pins_t pins;
   logic [3:0] rdata, dq_o, q, dq_i;
   int failures = 0, checks_done = 0, cyc = 0;
   // undriven bus shows the inverse of the model word
   assign dq_i = !dq_oe_n ? dq_o : oe ? q : ~q;
   sram_host sram_host_i (.clk_i(clk_i), .rstn_i(rstn_i),
      .req_valid_i(req_valid_i), .req_i(req_i), .req_ready_o(rv),
      .rdata_valid_o(oe_v), .rdata_o(rdata), .pins_o(pins), .dq_i(dq_i),
      .dq_o(dq_o), .dq_oe_n_o(dq_oe_n));
   sram_model sram_model_i (.pins_i(pins), .dq_i(dq_i), .q_o(q), .oe_o(oe));
   initial forever #20 clk_i = ~clk_i;
   task give_verdict;
      $display("checks %0d mismatches %0d", checks_done, failures);
      if (failures == 0 && checks_done > 0) $display("== PASSED ==");
      else $display("== FAILED ==");
      $finish;
   endtask
   always @(posedge clk_i) if (++cyc == 3000) begin
      failures++;
      give_verdict;
   end
   task req(input logic w, input logic [13:0] a, input logic [3:0] d);
      int n;
      n = 0;
      while (rv !== 1'b1 && n < 50) begin @(posedge clk_i); #1; n++; end
      `CHK("req_ready", 1'b1, rv)
      req_valid_i = 1;
      req_i = {w, a, d};
      @(posedge clk_i); #1;
      req_valid_i = 0;
   endtask
   task rd(input logic [13:0] a, input logic [3:0] e);
      int n;
      req(1'b0, a, 4'h0);
      n = 0;
      while (oe_v !== 1'b1 && n < 20) begin @(posedge clk_i); #1; n++; end
      `CHK("read latency", READ_WAIT, n)
      `CHK("rdata", e, rdata)
   endtask
   task test_edges;
      req(1'b1, 14'h0000, 4'hA);
      req(1'b1, 14'h3FFF, 4'h5);
      rd(14'h0000, 4'hA);
      rd(14'h3FFF, 4'h5);
      $display("done edges");
   endtask
   task test_rewrite;
      req(1'b1, 14'h1234, 4'hF);
      req(1'b1, 14'h1234, 4'h0);
      rd(14'h1234, 4'h0);
      repeat (40) @(posedge clk_i);
      #1 rd(14'h1234, 4'h0);
      $display("done rewrite");
   endtask
   task test_reset;
      rstn_i = 0;
      repeat (2) @(posedge clk_i);
      #1;
      `CHK("ready in reset", 1'b0, rv)
      `CHK("valid in reset", 1'b0, oe_v)
      `CHK("select in reset", 1'b1, pins.chip_sel_n)
      `CHK("drive in reset", 1'b1, dq_oe_n)
      rstn_i = 1;
      rd(14'h3FFF, 4'h5);
      $display("done reset");
   endtask
   initial begin
      repeat (16) @(posedge clk_i);
      #1 rstn_i = 1;
      test_edges;
      test_rewrite;
      test_reset;
      give_verdict;
   end
endmodule // test_sram_host
